// ==== gpf_pkg.sv ====
// Constants shared by the pin, video filter and parity inject register block
// Overview of operation
// - Remote select bits route deserializer GPIO to pins
// - Output value drives pin when local and enabled
// - Upper enable bits turn pin drivers on
// - Lower enable bits let pin samples in
// - Pass-any bit forwards every long type
// - Compare enable forwards packets equal to value
// - Compare value frozen while compare enabled
// - YUV10 types pass at 100 MHz rate
// - Frame valid polarity inverts on config bit
// - Line valid polarity inverts on config bit
// - Six-bit compare value, upper bits reserved
// - Compare matches only for long type values
// - Trigger write injects counted parity errors
// - BIST entry injects counted errors automatically
// - Seven-bit inject count, resets to zero
package gpf_pkg;
  // ***************************************************************
  // Register offsets and widths
  // ***************************************************************
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;
  localparam logic [7:0] OFF_LOCAL_PIN_SOURCE = 8'h0D;
  localparam logic [7:0] OFF_PIN_DIRECTION_ENABLES = 8'h0E;
  localparam logic [7:0] OFF_VIDEO_FILTER_CONFIG = 8'h10;
  localparam logic [7:0] OFF_VIDEO_FILTER_TYPE_VALUE = 8'h11;
  localparam logic [7:0] OFF_PARITY_ERROR_INJECT = 8'h13;
  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int NPINS = 4;
  localparam int POS_REMOTE_SEL = 4;
  localparam int POS_OUT_VALUE = 0;
  localparam int POS_DRIVE_EN = 4;
  localparam int POS_SAMPLE_EN = 0;
  localparam int POS_PASS_ANY = 4;
  localparam int POS_CMP_EN = 3;
  localparam int POS_YUV10 = 2;
  localparam int POS_FV_INV = 1;
  localparam int POS_LV_INV = 0;
  localparam int TYPE_W = 6;
  localparam int POS_TRIGGER = 7;
  localparam int CNT_W = 7;
  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [3:0] RST_REMOTE_SEL = 4'hF;
  localparam logic [3:0] RST_OUT_VALUE = 4'h0;
  localparam logic [3:0] RST_DRIVE_EN = 4'h0;
  localparam logic [3:0] RST_SAMPLE_EN = 4'hF;
  localparam logic [4:0] RST_FILTER_CFG = 5'h00;
  localparam logic [5:0] RST_TYPE_VALUE = 6'h00;
  localparam logic [6:0] RST_INJECT_CNT = 7'h00;
  // ***************************************************************
  // Data types and timing
  // ***************************************************************
  localparam logic [5:0] DT_YUV10_A = 6'h19;
  localparam logic [5:0] DT_YUV10_B = 6'h1D;
  localparam logic [5:0] DT_YUV10_C = 6'h1F;
  localparam int PIN_SYNC_STAGES = 3;
  localparam int READ_LATENCY = 1;

  // Long types have bit 5 or bit 4 set
  function automatic logic gpf_is_long(input logic [5:0] dt);
    gpf_is_long = dt[5] | dt[4];
  endfunction
endpackage

// ==== gpf_inj_if.sv ====
// Interface joining the register block to the parity error injector
`timescale 1ns/10ps
interface gpf_inj_if;
  logic start;
  logic [6:0] count;
  logic slot;
  logic err;
  logic done;
  modport ctl (output start, output count, output slot, input err, input done);
  modport inj (input start, input count, input slot, output err, output done);
endinterface

// ==== gpf_err_inject.sv ====
// Forward-channel parity error burst generator
`timescale 1ns/10ps
module gpf_err_inject (
  // Clock and synchronised reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control from the register block
  gpf_inj_if.inj inj
);
  import gpf_pkg::*;

  logic active_q;
  logic [CNT_W-1:0] left_q;
  logic err_q;
  logic done_q;

  // ***************************************************************
  // Burst counter
  // ***************************************************************
  // A new start reloads even mid-burst, so software always wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      left_q <= '0;
    end else if (inj.start) begin
      active_q <= 1'b1;
      left_q <= inj.count;
    end else if (active_q && left_q == '0) begin
      active_q <= 1'b0;
    end else if (active_q && inj.slot) begin
      left_q <= left_q - 1'b1;
    end
  end

  // One error per parity slot of the generator, one done pulse at the end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      err_q <= active_q && !inj.start && left_q != '0 && inj.slot;
      done_q <= active_q && !inj.start && left_q == '0;
    end
  end

  assign inj.err = err_q;
  assign inj.done = done_q;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_empty;
    active_q && !inj.start && left_q == '0;
  endsequence

  burst_end_a: assert property (s_empty |=> done_q && !active_q)
    else $error("burst did not end when count reached zero");
  err_gate_a: assert property (err_q |-> $past(active_q) && $past(left_q) != '0)
    else $error("parity error forced outside a burst");
  zero_burst_a: assert property (inj.start && inj.count == '0 ##1 !inj.start |=> done_q)
    else $error("zero count burst did not finish at once");
endmodule

// ==== gpf_regs.sv ====
// Pin source, video type filter and parity inject register block
`timescale 1ns/10ps
module gpf_regs #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Control channel register access
  input wire logic [gpf_pkg::REG_AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [gpf_pkg::REG_DW-1:0] reg_wdata,
  output logic [gpf_pkg::REG_DW-1:0] reg_rdata,
  output logic reg_rvalid,
  // Pins
  input wire logic [gpf_pkg::NPINS-1:0] remote_gpio,
  input wire logic [gpf_pkg::NPINS-1:0] pin_i,
  output logic [gpf_pkg::NPINS-1:0] pin_o,
  output logic [gpf_pkg::NPINS-1:0] pin_oe,
  output logic [gpf_pkg::NPINS-1:0] pin_sample,
  // Rate and mode selects
  input wire logic rate_100m_select,
  input wire logic rate_75m_select,
  input wire logic bist_mode,
  // Incoming image packets
  input wire logic in_valid,
  input wire logic [gpf_pkg::TYPE_W-1:0] in_type,
  input wire logic [DATA_W-1:0] in_data,
  input wire logic in_frame_valid,
  input wire logic in_line_valid,
  // Filtered packets toward the serial link
  output logic out_valid,
  output logic [gpf_pkg::TYPE_W-1:0] out_type,
  output logic [DATA_W-1:0] out_data,
  output logic out_frame_valid,
  output logic out_line_valid,
  // Parity error injection
  input wire logic fc_parity_slot,
  output logic fc_parity_err
);
  import gpf_pkg::*;

  // Refuse packet widths the data path cannot carry
  if (DATA_W < 1 || DATA_W > 64) begin : g_bad_width
    $error("DATA_W out of range");
  end

  // ***************************************************************
  // Reset release
  // ***************************************************************
  logic rst_meta_q;
  logic rst_n;

  // Assert at once, release through two flops to avoid recovery races
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [3:0] remote_pin_select_q;
  logic [3:0] pin_output_value_q;
  logic [3:0] pin_drive_enable_q;
  logic [3:0] pin_sample_enable_q;
  logic pass_any_long_type_q;
  logic type_compare_enable_q;
  logic pass_yuv10_types_q;
  logic frame_valid_invert_q;
  logic line_valid_invert_q;
  logic [TYPE_W-1:0] compare_type_value_q;
  logic inject_parity_trigger_q;
  logic [CNT_W-1:0] inject_parity_count_q;
  logic bist_seen_q;
  logic start_d;
  logic start_q;
  gpf_inj_if inj ();

  logic wr_src;
  logic wr_dir;
  logic wr_cfg;
  logic wr_type;
  logic wr_inj;
  assign wr_src = reg_wr && reg_addr == OFF_LOCAL_PIN_SOURCE;
  assign wr_dir = reg_wr && reg_addr == OFF_PIN_DIRECTION_ENABLES;
  assign wr_cfg = reg_wr && reg_addr == OFF_VIDEO_FILTER_CONFIG;
  assign wr_type = reg_wr && reg_addr == OFF_VIDEO_FILTER_TYPE_VALUE;
  assign wr_inj = reg_wr && reg_addr == OFF_PARITY_ERROR_INJECT;

  // Pin source register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_pin_select_q <= RST_REMOTE_SEL;
      pin_output_value_q <= RST_OUT_VALUE;
    end else if (wr_src) begin
      remote_pin_select_q <= reg_wdata[POS_REMOTE_SEL +: NPINS];
      pin_output_value_q <= reg_wdata[POS_OUT_VALUE +: NPINS];
    end
  end

  // Pin direction register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_drive_enable_q <= RST_DRIVE_EN;
      pin_sample_enable_q <= RST_SAMPLE_EN;
    end else if (wr_dir) begin
      pin_drive_enable_q <= reg_wdata[POS_DRIVE_EN +: NPINS];
      pin_sample_enable_q <= reg_wdata[POS_SAMPLE_EN +: NPINS];
    end
  end

  // Filter configuration; bits 7:5 are reserved and not stored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pass_any_long_type_q, type_compare_enable_q, pass_yuv10_types_q,
       frame_valid_invert_q, line_valid_invert_q} <= RST_FILTER_CFG;
    end else if (wr_cfg) begin
      pass_any_long_type_q <= reg_wdata[POS_PASS_ANY];
      type_compare_enable_q <= reg_wdata[POS_CMP_EN];
      pass_yuv10_types_q <= reg_wdata[POS_YUV10];
      frame_valid_invert_q <= reg_wdata[POS_FV_INV];
      line_valid_invert_q <= reg_wdata[POS_LV_INV];
    end
  end

  // Compare value; locked so the match target cannot move under traffic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_type_value_q <= RST_TYPE_VALUE;
    end else if (wr_type && !type_compare_enable_q) begin
      compare_type_value_q <= reg_wdata[TYPE_W-1:0];
    end
  end

  // Inject count field
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      inject_parity_count_q <= RST_INJECT_CNT;
    end else if (wr_inj) begin
      inject_parity_count_q <= reg_wdata[CNT_W-1:0];
    end
  end

  // A burst starts on a trigger write or on BIST mode entry
  assign start_d = (wr_inj && reg_wdata[POS_TRIGGER])
                   || (bist_mode && !bist_seen_q);

  // Self-clearing trigger; a new start beats the done of the old burst
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      inject_parity_trigger_q <= 1'b0;
      bist_seen_q <= 1'b0;
    end else begin
      bist_seen_q <= bist_mode;
      if (start_d) begin
        inject_parity_trigger_q <= 1'b1;
      end else if (inj.done && !start_q) begin
        inject_parity_trigger_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Parity error injector
  // ***************************************************************
  // Start is registered so the count written in the same cycle is used
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_d;
    end
  end

  assign inj.start = start_q;
  assign inj.count = inject_parity_count_q;
  assign inj.slot = fc_parity_slot;
  assign fc_parity_err = inj.err;

  gpf_err_inject u_inject (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inj(inj)
  );

  // ***************************************************************
  // Register read back
  // ***************************************************************
  logic [REG_DW-1:0] rd_mux;

  // Unmapped and reserved bits read as zero
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      OFF_LOCAL_PIN_SOURCE: rd_mux = {remote_pin_select_q, pin_output_value_q};
      OFF_PIN_DIRECTION_ENABLES: rd_mux = {pin_drive_enable_q, pin_sample_enable_q};
      OFF_VIDEO_FILTER_CONFIG: rd_mux = {3'h0, pass_any_long_type_q,
        type_compare_enable_q, pass_yuv10_types_q, frame_valid_invert_q,
        line_valid_invert_q};
      OFF_VIDEO_FILTER_TYPE_VALUE: rd_mux = {2'h0, compare_type_value_q};
      OFF_PARITY_ERROR_INJECT: rd_mux = {inject_parity_trigger_q, inject_parity_count_q};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ***************************************************************
  // Pins
  // ***************************************************************
  logic [NPINS-1:0] sync1_q;
  logic [NPINS-1:0] sync2_q;
  logic [NPINS-1:0] sync3_q;
  logic [NPINS-1:0] pin_stable_q;

  // Three-stage capture; a bit counts only once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      pin_stable_q <= '0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_stable_q <= (sync2_q & ~(sync2_q ^ sync3_q)) | (pin_stable_q & (sync2_q ^ sync3_q));
    end
  end

  // Remote data takes the pin over the local value, per bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o <= '0;
      pin_oe <= '0;
      pin_sample <= '0;
    end else begin
      pin_o <= (remote_pin_select_q & remote_gpio)
               | (~remote_pin_select_q & pin_drive_enable_q & pin_output_value_q);
      pin_oe <= pin_drive_enable_q | remote_pin_select_q;
      pin_sample <= pin_stable_q & pin_sample_enable_q;
    end
  end

  // ***************************************************************
  // Video type filter
  // ***************************************************************
  logic pass_any;
  logic pass_cmp;
  logic pass_yuv;
  assign pass_any = pass_any_long_type_q && gpf_is_long(in_type);
  assign pass_cmp = type_compare_enable_q && gpf_is_long(compare_type_value_q)
                    && in_type == compare_type_value_q;
  assign pass_yuv = pass_yuv10_types_q && rate_100m_select
                    && (in_type == DT_YUV10_A || in_type == DT_YUV10_B
                        || in_type == DT_YUV10_C);

  // One register stage; the 75 MHz select never blocks a compare match
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_type <= '0;
      out_data <= '0;
      out_frame_valid <= 1'b0;
      out_line_valid <= 1'b0;
    end else begin
      out_valid <= in_valid && (pass_any || pass_cmp || pass_yuv);
      out_type <= in_type;
      out_data <= in_data;
      out_frame_valid <= in_frame_valid ^ frame_valid_invert_q;
      out_line_valid <= in_line_valid ^ line_valid_invert_q;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_locked_write;
    type_compare_enable_q && wr_type;
  endsequence

  remote_route_a: assert property (##1 ((pin_o ^ $past(remote_gpio))
    & $past(remote_pin_select_q)) == 4'h0)
    else $error("remote pin data not routed");
  local_drive_a: assert property (##1 ((pin_o ^ $past(pin_output_value_q))
    & ~$past(remote_pin_select_q) & $past(pin_drive_enable_q)) == 4'h0)
    else $error("local pin value not driven");
  drive_off_a: assert property (##1 (pin_oe & ~$past(pin_drive_enable_q)
    & ~$past(remote_pin_select_q)) == 4'h0)
    else $error("pin driven while disabled");
  sample_gate_a: assert property (##1 (pin_sample & ~$past(pin_sample_enable_q)) == 4'h0)
    else $error("sample seen while input disabled");
  value_lock_a: assert property (s_locked_write |=> $stable(compare_type_value_q))
    else $error("compare value changed while locked");
  long_pass_a: assert property (in_valid && pass_any_long_type_q && gpf_is_long(in_type)
    |=> out_valid)
    else $error("long packet dropped");
  cmp_any_rate_a: assert property (in_valid && pass_cmp && rate_75m_select |=> out_valid)
    else $error("compare match blocked by rate select");
  short_cmp_a: assert property (!pass_any_long_type_q && !pass_yuv10_types_q
    && !gpf_is_long(compare_type_value_q) |=> !out_valid)
    else $error("short compare value matched");
  yuv_pass_a: assert property (in_valid && pass_yuv10_types_q && rate_100m_select
    && in_type == DT_YUV10_B |=> out_valid)
    else $error("yuv10 packet dropped");
  polarity_a: assert property (##1 out_frame_valid == ($past(in_frame_valid)
    ^ $past(frame_valid_invert_q)) && out_line_valid == ($past(in_line_valid)
    ^ $past(line_valid_invert_q)))
    else $error("valid polarity wrong");
  bist_entry_a: assert property ($rose(bist_mode) |=> inject_parity_trigger_q && start_q)
    else $error("bist entry did not start a burst");
endmodule

// ==== gpf_remote_model.sv ====
// Remote deserializer stand-in: GPIO values and parity slot pacing
`timescale 1ns/10ps
module gpf_remote_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bench control
  input wire logic [3:0] gpio_val,
  input wire logic slow,
  // Toward the block
  output logic [3:0] remote_gpio,
  output logic fc_parity_slot,
  input wire logic fc_parity_err,
  // Observed forced errors
  output logic [7:0] err_seen,
  output logic [7:0] err_stray
);
  logic [1:0] pace_q;
  logic slot_q;
  // ****************
  // Slot pacing
  // ****************
  // Slow mode offers a slot only every fourth cycle, to stretch bursts
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pace_q <= 2'h0;
      fc_parity_slot <= 1'b0;
      slot_q <= 1'b0;
    end else begin
      pace_q <= pace_q + 2'h1;
      fc_parity_slot <= slow ? (pace_q == 2'h3) : 1'b1;
      slot_q <= fc_parity_slot;
    end
  end
  // Remote GPIO levels, same clock as the block
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_gpio <= 4'h0;
    end else begin
      remote_gpio <= gpio_val;
    end
  end
  // ****************
  // Error counting
  // ****************
  // An error with no slot in the cycle before counts as stray
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_seen <= 8'h00;
      err_stray <= 8'h00;
    end else if (fc_parity_err) begin
      err_seen <= err_seen + 8'h01;
      if (!slot_q) begin
        err_stray <= err_stray + 8'h01;
      end
    end
  end
endmodule

// ==== gpf_regs_bench.sv ====
// Self-checking bench for the pin, video filter and parity inject registers
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module gpf_regs_bench;
  import gpf_pkg::*;
  logic core_clk, nrst, reg_wr, reg_rd, reg_rvalid, slow;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_q, err_seen, err_stray;
  logic [3:0] gpio_val, remote_gpio, pin_i, pin_o, pin_oe, pin_sample;
  logic rate_100m_select, rate_75m_select, bist_mode, in_valid, out_valid;
  logic in_frame_valid, in_line_valid, out_frame_valid, out_line_valid;
  logic [5:0] in_type, out_type;
  logic [15:0] in_data, out_data;
  logic fc_parity_slot, fc_parity_err;
  logic [5:0] yuv_tab [3] = '{DT_YUV10_A, DT_YUV10_B, DT_YUV10_C};
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  gpf_regs #(.DATA_W(16)) gpf_regs_i (.core_clk, .nrst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .remote_gpio, .pin_i, .pin_o, .pin_oe,
    .pin_sample, .rate_100m_select, .rate_75m_select, .bist_mode, .in_valid, .in_type,
    .in_data, .in_frame_valid, .in_line_valid, .out_valid, .out_type, .out_data,
    .out_frame_valid, .out_line_valid, .fc_parity_slot, .fc_parity_err);
  gpf_remote_model gpf_remote_model_i (.core_clk, .rst_n(nrst), .gpio_val, .slow,
    .remote_gpio, .fc_parity_slot, .fc_parity_err, .err_seen, .err_stray);
  // Clock, 20 ns period
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Hang guard, far above the roughly two hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ****************
  // Access tasks
  // ****************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Answer stands one cycle, so it is sampled just after the taking edge
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rvalid, 1'b1)
    rd_q = reg_rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rd_q, e)
  endtask
  task automatic send(input logic [5:0] t, input logic e);
    @(posedge core_clk);
    in_valid <= 1'b1;
    in_type <= t;
    in_data <= {10'h2A5, t};
    @(posedge core_clk);
    in_valid <= 1'b0;
    #1;
    `CHK(out_valid, e)
    `CHK(out_data, {10'h2A5, t})
    `CHK(out_type, t)
  endtask
  // Poll the trigger until it clears, bounded
  task automatic wait_idle();
    int k;
    k = 0;
    rd(OFF_PARITY_ERROR_INJECT);
    while (rd_q[7] !== 1'b0 && k < 100) begin
      rd(OFF_PARITY_ERROR_INJECT);
      k++;
    end
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, slow, gpio_val, pin_i} = '0;
    {rate_100m_select, rate_75m_select, bist_mode, in_valid, in_type, in_data} = '0;
    {in_frame_valid, in_line_valid} = '0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    // Reset values and an unmapped place
    rdchk(OFF_LOCAL_PIN_SOURCE, 8'hF0);
    rdchk(OFF_PIN_DIRECTION_ENABLES, 8'h0F);
    rdchk(OFF_VIDEO_FILTER_CONFIG, 8'h00);
    rdchk(OFF_VIDEO_FILTER_TYPE_VALUE, 8'h00);
    rdchk(OFF_PARITY_ERROR_INJECT, 8'h00);
    wr(8'h12, 8'hFF);
    rdchk(8'h12, 8'h00);
    // Pins: all remote, then a local and remote mix
    gpio_val <= 4'h9;
    repeat (3) @(posedge core_clk);
    `CHK(pin_o, 4'h9)
    `CHK(pin_oe, 4'hF)
    wr(OFF_LOCAL_PIN_SOURCE, 8'h35);
    wr(OFF_PIN_DIRECTION_ENABLES, 8'h4F);
    pin_i <= 4'hA;
    repeat (8) @(posedge core_clk);
    `CHK(pin_o, 4'h5)
    `CHK(pin_oe, 4'h7)
    `CHK(pin_sample, 4'hA)
    wr(OFF_PIN_DIRECTION_ENABLES, 8'h45);
    repeat (3) @(posedge core_clk);
    `CHK(pin_sample, 4'h0)
    rdchk(OFF_PIN_DIRECTION_ENABLES, 8'h45);
    // Type filter modes
    wr(OFF_VIDEO_FILTER_CONFIG, 8'h10);
    send(6'h12, 1'b1);
    send(6'h0F, 1'b0);
    wr(OFF_VIDEO_FILTER_TYPE_VALUE, 8'hEA);
    rdchk(OFF_VIDEO_FILTER_TYPE_VALUE, 8'h2A);
    wr(OFF_VIDEO_FILTER_CONFIG, 8'h08);
    send(6'h2A, 1'b1);
    send(6'h12, 1'b0);
    @(posedge core_clk) rate_75m_select <= 1'b1;
    send(6'h2A, 1'b1);
    wr(OFF_VIDEO_FILTER_TYPE_VALUE, 8'h15);
    rdchk(OFF_VIDEO_FILTER_TYPE_VALUE, 8'h2A);
    wr(OFF_VIDEO_FILTER_CONFIG, 8'h00);
    wr(OFF_VIDEO_FILTER_TYPE_VALUE, 8'h05);
    wr(OFF_VIDEO_FILTER_CONFIG, 8'h08);
    send(6'h05, 1'b0);
    wr(OFF_VIDEO_FILTER_CONFIG, 8'h04);
    send(DT_YUV10_A, 1'b0);
    @(posedge core_clk) rate_100m_select <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      send(yuv_tab[i], 1'b1);
    end
    send(6'h1A, 1'b0);
    // Frame and line valid polarity, every setting
    @(posedge core_clk) in_frame_valid <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(OFF_VIDEO_FILTER_CONFIG, 8'(c));
      repeat (2) @(posedge core_clk);
      `CHK(out_frame_valid, ~c[1])
      `CHK(out_line_valid, c[0])
    end
    // Triggered bursts, slow then fast slots
    slow <= 1'b1;
    wr(OFF_PARITY_ERROR_INJECT, 8'h83);
    rdchk(OFF_PARITY_ERROR_INJECT, 8'h83);
    wait_idle();
    `CHK(rd_q, 8'h03)
    `CHK(err_seen, 8'd3)
    @(posedge core_clk) slow <= 1'b0;
    wr(OFF_PARITY_ERROR_INJECT, 8'h80);
    wait_idle();
    `CHK(err_seen, 8'd3)
    wr(OFF_PARITY_ERROR_INJECT, 8'h82);
    wait_idle();
    `CHK(err_seen, 8'd5)
    // Count alone does nothing; entering BIST fires it
    wr(OFF_PARITY_ERROR_INJECT, 8'h05);
    repeat (10) @(posedge core_clk);
    `CHK(err_seen, 8'd5)
    bist_mode <= 1'b1;
    repeat (30) @(posedge core_clk);
    `CHK(err_seen, 8'd10)
    `CHK(err_stray, 8'd0)
    complete_run();
  end
endmodule
